// file: hpa_pkg.sv
// constants, register map and access codes shared by the host port files
package hpa_pkg;

    // register byte addresses
    localparam logic [31:0] OFF_PORT_CFG = 32'h4000_0008;
    localparam logic [31:0] OFF_ADDR_TOP = 32'h4000_000c;
    localparam logic [31:0] OFF_ADDR_UMB = 32'h4000_0010;
    localparam logic [31:0] OFF_PERIPH_ID = 32'h4300_0000;
    localparam logic [31:0] OFF_PWR_EMU = 32'h4300_0004;
    localparam logic [31:0] OFF_GPIO_INT = 32'h4300_0008;
    localparam logic [31:0] OFF_GPIO_EN = 32'h4300_000c;
    localparam logic [31:0] OFF_GPIO_DIR1 = 32'h4300_0010;
    localparam logic [31:0] OFF_GPIO_VAL1 = 32'h4300_0014;
    localparam logic [31:0] OFF_GPIO_DIR2 = 32'h4300_0018;
    localparam logic [31:0] OFF_GPIO_VAL2 = 32'h4300_001c;
    localparam logic [31:0] OFF_GPIO_DIR3 = 32'h4300_0020;
    localparam logic [31:0] OFF_GPIO_VAL3 = 32'h4300_0024;
    localparam logic [31:0] OFF_RSVD_A = 32'h4300_0028;
    localparam logic [31:0] OFF_RSVD_B = 32'h4300_002c;
    localparam logic [31:0] OFF_HOST_CTL = 32'h4300_0030;
    localparam logic [31:0] OFF_WR_PTR = 32'h4300_0034;
    localparam logic [31:0] OFF_RD_PTR = 32'h4300_0038;
    localparam logic [31:0] OFF_RSVD_C = 32'h4300_003c;
    localparam logic [31:0] OFF_RSVD_D = 32'h4300_0040;

    // port configuration fields
    localparam int CFG_W = 5;
    localparam int CFG_ENA_BIT = 0;
    localparam int CFG_PAGE_BIT = 1;
    localparam int CFG_NONMULTIPLEXED_ENABLE_BIT = 2;
    localparam int CFG_FULL_BIT = 3;
    localparam int CFG_BYTEAD_BIT = 4;
    localparam logic [CFG_W-1:0] CFG_RST = 5'h00;

    // page byte registers
    localparam int PAGE_W = 8;
    localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;

    // host port control fields
    localparam int CTL_PROC_INT_BIT = 1;
    localparam int CTL_HOST_INT_BIT = 2;

    // gpio enable: upper half of the host data bus handed to gpio
    localparam int GPIO_EN_UPPER_BIT = 0;
    localparam int PWR_W = 2;
    localparam logic [PWR_W-1:0] PWR_RST = 2'h0;
    localparam logic [31:0] GPIO_RST = 32'h0000_0000;

    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] STEP_WORD = 32'h0000_0001;
    localparam logic [31:0] STEP_BYTE = 32'h0000_0004;

    // synchronised host pin vector
    localparam int PIN_W = 59;

    typedef enum logic [1:0] {
        HPA_ACC_CTRL = 2'b00,
        HPA_ACC_DATA_INC = 2'b01,
        HPA_ACC_ADDR = 2'b10,
        HPA_ACC_DATA = 2'b11
    } hpa_access_t;

endpackage

// file: hpa_sync.sv
// three-stage synchroniser for host pins, exposing the last two stages
`timescale 1ns/100ps
module hpa_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q2,
    output logic [W-1:0] q3
);
    logic [W-1:0] q1;

    if (W < 1)
    begin : g_bad_w
        $error("hpa_sync width must be at least one");
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q1 <= '1;
            q2 <= '1;
            q3 <= '1;
        end
        else
        begin
            q1 <= d;
            q2 <= q1;
            q3 <= q2;
        end
    end
endmodule

// file: hpa_host_port.sv
// host port: strobe-framed host access to internal space, apb register slave
`timescale 1ns/100ps
module hpa_host_port #(
    parameter logic [31:0] PERIPH_ID = 32'h0001_0000 // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_chip_select_n,
    input wire logic [1:0] host_data_strobes_n,
    input wire logic host_address_strobe_n,
    input wire logic host_read_not_write,
    input wire logic [1:0] access_type_select,
    input wire logic [3:0] host_byte_enables_n,
    input wire logic [15:0] host_address_pins,
    input wire logic [31:0] host_data_in,
    output logic [31:0] host_data_out,
    output logic [31:0] host_data_oe_n,
    output logic host_ready_n,
    output logic host_interrupt_out_n,
    output logic proc_interrupt,
    input wire logic memory_init_done,
    output logic memory_upper_drive_enable,
    output logic bus_req,
    output logic bus_write,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata,
    output logic [3:0] bus_be,
    input wire logic bus_done,
    input wire logic [31:0] bus_rdata
);
    import hpa_pkg::*;

    typedef enum logic {ST_IDLE, ST_BUSY} hpa_state_t;

    logic [PIN_W-1:0] q2, q3, pin;
    logic [CFG_W-1:0] cfg;
    logic [PAGE_W-1:0] addr_top, addr_umb;
    logic [PWR_W-1:0] pwr_emu;
    logic [31:0] gpio_en, gpio_dir, gpio_val;
    logic host_int, proc_int;
    hpa_state_t state;
    logic [31:0] addr, hold;
    logic stb_q, open, pend, as_q, as_held;
    logic [1:0] as_type;
    logic as_read, as_half;
    hpa_access_t cur_type;
    logic cur_read, cur_half, cur_inc;
    logic [3:0] hold_be;

    // filtered host pins
    logic cs_n, as_n, rnw, half_sel;
    logic [1:0] ds_n, cntl;
    logic [3:0] be_n;
    logic [15:0] ha;
    logic [31:0] hd;
    logic stb, fall, rise, ena, nonmultiplexed_enable, full, halfmode, act, upper_gpio;
    logic [1:0] t_now;
    logic t_read, t_half, t_ok;
    logic host_ctl_wr, apb_ptr_wr, apb_ctl_wr, apb_wr;
    logic [31:0] rd_mux;
    logic rd_err;

    hpa_sync #(
        .W(PIN_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({host_chip_select_n, host_data_strobes_n, host_address_strobe_n,
            host_read_not_write, access_type_select, host_byte_enables_n,
            host_address_pins, host_data_in}),
        .q2(q2),
        .q3(q3)
    );

    // a pin change counts once the second and third stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin <= '1;
        end
        else
        begin
            pin <= (q3 & ~(q2 ^ q3)) | (pin & (q2 ^ q3));
        end
    end

    assign {cs_n, ds_n, as_n, rnw, cntl, be_n, ha, hd} = pin;
    assign half_sel = hd[16];
    assign ena = cfg[CFG_ENA_BIT];
    assign nonmultiplexed_enable = cfg[CFG_NONMULTIPLEXED_ENABLE_BIT];
    assign full = cfg[CFG_FULL_BIT];
    assign halfmode = !nonmultiplexed_enable && !full;
    assign upper_gpio = gpio_en[GPIO_EN_UPPER_BIT];

    // chip select low together with exactly one of the two data strobes low
    assign stb = !cs_n && (ds_n[1] ^ ds_n[0]);
    assign fall = stb && !stb_q;
    assign rise = !stb && stb_q;
    assign act = ena && (state == ST_IDLE) && stb && (fall || pend) && !open;

    // fields latched on address strobe fall take precedence when present
    assign t_now = as_held ? as_type : cntl;
    assign t_read = as_held ? as_read : rnw;
    assign t_half = as_held ? as_half : half_sel;
    assign t_ok = !nonmultiplexed_enable || (t_now == HPA_ACC_CTRL) || (t_now == HPA_ACC_DATA);

    function automatic logic [31:0] eff_addr(input logic [31:0] a, input logic [CFG_W-1:0] c,
                                             input logic [7:0] top, input logic [7:0] umb,
                                             input logic [15:0] pins);
        logic [31:0] b;
        b = c[CFG_BYTEAD_BIT] ? a : {a[29:0], 2'b00};
        if (c[CFG_NONMULTIPLEXED_ENABLE_BIT])
        begin
            b = c[CFG_BYTEAD_BIT] ? {16'h0000, pins} : {14'h0000, pins, 2'b00};
            eff_addr = {top, umb, b[15:0]};
        end
        else if (c[CFG_PAGE_BIT])
        begin
            eff_addr = {top, umb, b[15:0]};
        end
        else
        begin
            eff_addr = b;
        end
    endfunction

    function automatic logic [31:0] step(input logic [CFG_W-1:0] c);
        step = c[CFG_BYTEAD_BIT] ? STEP_BYTE : STEP_WORD;
    endfunction

    function automatic logic [31:0] ctl_word(input logic hi, input logic pi);
        ctl_word = '0;
        ctl_word[CTL_HOST_INT_BIT] = hi;
        ctl_word[CTL_PROC_INT_BIT] = pi;
    endfunction

    assign host_ctl_wr = rise && open && !cur_read && (cur_type == HPA_ACC_CTRL);
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_ptr_wr = apb_wr && ((paddr == OFF_WR_PTR) || (paddr == OFF_RD_PTR));
    assign apb_ctl_wr = apb_wr && (paddr == OFF_HOST_CTL);

    // host transaction sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            stb_q <= 1'b0;
            open <= 1'b0;
            pend <= 1'b0;
            as_q <= 1'b1;
            as_held <= 1'b0;
            as_type <= 2'b00;
            as_read <= 1'b0;
            as_half <= 1'b0;
            cur_type <= HPA_ACC_CTRL;
            cur_read <= 1'b0;
            cur_half <= 1'b0;
            cur_inc <= 1'b0;
            hold_be <= 4'h0;
            addr <= ADDR_RST;
            hold <= 32'h0000_0000;
            host_data_out <= 32'h0000_0000;
            host_data_oe_n <= 32'hffff_ffff;
            host_ready_n <= 1'b0;
            bus_req <= 1'b0;
            bus_write <= 1'b0;
            bus_addr <= 32'h0000_0000;
            bus_wdata <= 32'h0000_0000;
            bus_be <= 4'h0;
        end
        else
        begin
            stb_q <= stb;
            as_q <= as_n;
            if (as_q && !as_n && !nonmultiplexed_enable)
            begin
                as_held <= 1'b1;
                as_type <= cntl;
                as_read <= rnw;
                as_half <= half_sel;
            end
            if (fall && (state == ST_BUSY))
            begin
                pend <= 1'b1;
                host_ready_n <= 1'b1;
            end
            if (state == ST_BUSY)
            begin
                if (bus_done)
                begin
                    bus_req <= 1'b0;
                    state <= ST_IDLE;
                    host_ready_n <= pend || fall;
                    if (!bus_write)
                    begin
                        hold <= bus_rdata;
                        host_data_out <= halfmode ? {16'h0000, bus_rdata[15:0]} : bus_rdata;
                    end
                    if (cur_inc)
                    begin
                        addr <= addr + step(cfg);
                    end
                end
            end
            else if (act)
            begin
                pend <= 1'b0;
                as_held <= 1'b0;
                open <= 1'b1;
                cur_type <= hpa_access_t'(t_now);
                cur_read <= t_read;
                cur_half <= t_half;
                cur_inc <= 1'b0;
                if (t_read)
                begin
                    host_data_oe_n[15:0] <= 16'h0000;
                    if (halfmode && upper_gpio)
                    begin
                        host_data_oe_n[31:16] <= ~gpio_dir[31:16];
                    end
                    else
                    begin
                        host_data_oe_n[31:16] <= 16'h0000;
                    end
                end
                if (!t_ok || !t_read)
                begin
                    host_ready_n <= 1'b0;
                end
                else if (t_now == HPA_ACC_CTRL)
                begin
                    host_ready_n <= 1'b0;
                    host_data_out <= (halfmode && t_half) ? 32'h0000_0000
                                     : ctl_word(host_int, proc_int);
                end
                else if (t_now == HPA_ACC_ADDR)
                begin
                    host_ready_n <= 1'b0;
                    if (halfmode)
                    begin
                        host_data_out <= {16'h0000, t_half ? addr[31:16] : addr[15:0]};
                    end
                    else
                    begin
                        host_data_out <= addr;
                    end
                end
                else if (halfmode && t_half)
                begin
                    host_ready_n <= 1'b0;
                    host_data_out <= {16'h0000, hold[31:16]};
                    if (t_now == HPA_ACC_DATA_INC)
                    begin
                        addr <= addr + step(cfg);
                    end
                end
                else
                begin
                    state <= ST_BUSY;
                    host_ready_n <= 1'b1;
                    bus_req <= 1'b1;
                    bus_write <= 1'b0;
                    bus_addr <= eff_addr(addr, cfg, addr_top, addr_umb, ha);
                    bus_be <= 4'hf;
                    cur_inc <= (t_now == HPA_ACC_DATA_INC) && !halfmode;
                end
            end
            if (rise && open && (state == ST_IDLE))
            begin
                open <= 1'b0;
                host_data_oe_n <= 32'hffff_ffff;
                if (!cur_read && (!nonmultiplexed_enable || cur_type == HPA_ACC_CTRL || cur_type == HPA_ACC_DATA))
                begin
                    unique case (cur_type)
                        HPA_ACC_CTRL:
                        begin
                        end
                        HPA_ACC_ADDR:
                        begin
                            if (!halfmode)
                            begin
                                addr <= hd;
                            end
                            else if (cur_half)
                            begin
                                addr[31:16] <= hd[15:0];
                            end
                            else
                            begin
                                addr[15:0] <= hd[15:0];
                            end
                        end
                        HPA_ACC_DATA_INC, HPA_ACC_DATA:
                        begin
                            if (halfmode && !cur_half)
                            begin
                                hold[15:0] <= hd[15:0];
                                hold_be <= {2'b00, ~be_n[1:0]};
                            end
                            else
                            begin
                                state <= ST_BUSY;
                                host_ready_n <= pend;
                                bus_req <= 1'b1;
                                bus_write <= 1'b1;
                                bus_addr <= eff_addr(addr, cfg, addr_top, addr_umb, ha);
                                bus_wdata <= halfmode ? {hd[15:0], hold[15:0]} : hd;
                                bus_be <= halfmode ? {~be_n[1:0], hold_be[1:0]} : ~be_n;
                                cur_inc <= (cur_type == HPA_ACC_DATA_INC);
                            end
                        end
                    endcase
                end
            end
            if (apb_ptr_wr && (state == ST_IDLE) && !open)
            begin
                addr <= pwdata;
            end
        end
    end

    // interrupts both ways; a set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_int <= 1'b0;
            proc_int <= 1'b0;
            host_interrupt_out_n <= 1'b1;
            proc_interrupt <= 1'b0;
        end
        else
        begin
            if (apb_ctl_wr && pwdata[CTL_HOST_INT_BIT])
            begin
                host_int <= 1'b1;
            end
            else if (host_ctl_wr && hd[CTL_HOST_INT_BIT])
            begin
                host_int <= 1'b0;
            end
            if (host_ctl_wr && hd[CTL_PROC_INT_BIT])
            begin
                proc_int <= 1'b1;
            end
            else if (apb_ctl_wr && pwdata[CTL_PROC_INT_BIT])
            begin
                proc_int <= 1'b0;
            end
            host_interrupt_out_n <= !host_int;
            proc_interrupt <= proc_int;
        end
    end

    // shared upper pins: memory interface drives only after init, never in nonmultiplexed_enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            memory_upper_drive_enable <= 1'b0;
        end
        else
        begin
            memory_upper_drive_enable <= memory_init_done && !nonmultiplexed_enable;
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        unique case (paddr)
            OFF_PORT_CFG: rd_mux = {27'h000_0000, cfg};
            OFF_ADDR_TOP: rd_mux = {24'h00_0000, addr_top};
            OFF_ADDR_UMB: rd_mux = {24'h00_0000, addr_umb};
            OFF_PERIPH_ID: rd_mux = PERIPH_ID;
            OFF_PWR_EMU: rd_mux = {30'h0000_0000, pwr_emu};
            OFF_GPIO_EN: rd_mux = gpio_en;
            OFF_GPIO_DIR1: rd_mux = gpio_dir;
            OFF_GPIO_VAL1: rd_mux = (gpio_dir & gpio_val) | (~gpio_dir & hd);
            OFF_HOST_CTL: rd_mux = ctl_word(host_int, proc_int);
            OFF_WR_PTR, OFF_RD_PTR: rd_mux = addr;
            OFF_GPIO_INT, OFF_GPIO_DIR2, OFF_GPIO_VAL2, OFF_GPIO_DIR3, OFF_GPIO_VAL3,
            OFF_RSVD_A, OFF_RSVD_B, OFF_RSVD_C, OFF_RSVD_D: rd_mux = 32'h0000_0000;
            default: rd_err = 1'b1;
        endcase
    end

    // apb slave: one wait-free access phase, answer registered at setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && rd_err;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // software-written configuration; the page bytes have no host path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg <= CFG_RST;
            addr_top <= PAGE_RST;
            addr_umb <= PAGE_RST;
            pwr_emu <= PWR_RST;
            gpio_en <= GPIO_RST;
            gpio_dir <= GPIO_RST;
            gpio_val <= GPIO_RST;
        end
        else if (apb_wr)
        begin
            unique case (paddr)
                OFF_PORT_CFG: cfg <= pwdata[CFG_W-1:0];
                OFF_ADDR_TOP: addr_top <= pwdata[PAGE_W-1:0];
                OFF_ADDR_UMB: addr_umb <= pwdata[PAGE_W-1:0];
                OFF_PWR_EMU: pwr_emu <= pwdata[PWR_W-1:0];
                OFF_GPIO_EN: gpio_en <= pwdata;
                OFF_GPIO_DIR1: gpio_dir <= pwdata;
                OFF_GPIO_VAL1: gpio_val <= pwdata;
                default:
                begin
                end
            endcase
        end
    end
endmodule

// file: hpa_monitor.sv
// assertions on the host port's top-level ports
`timescale 1ns/100ps
module hpa_monitor
    import hpa_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic pready,
    input wire logic host_ready_n,
    input wire logic host_interrupt_out_n,
    input wire logic proc_interrupt,
    input wire logic memory_init_done,
    input wire logic memory_upper_drive_enable,
    input wire logic bus_req,
    input wire logic [31:0] bus_addr,
    input wire logic bus_done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic ctl_wr;
    assign ctl_wr = psel && penable && pwrite && paddr == OFF_HOST_CTL;
    property p_apb_rdy; psel && !penable |=> pready; endproperty
    a_apb_rdy: assert property (p_apb_rdy) else $error("no pready after setup");
    property p_wait; host_ready_n && bus_req && !bus_done |=> host_ready_n; endproperty
    a_wait: assert property (p_wait) else $error("ready before access done");
    property p_rdy_rise; $rose(host_ready_n) |-> bus_req; endproperty
    a_rdy_rise: assert property (p_rdy_rise) else $error("wait with no access");
    property p_req_hold; bus_req && !bus_done |=> bus_req && $stable(bus_addr); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request not held");
    property p_req_end; bus_done |=> !bus_req; endproperty
    a_req_end: assert property (p_req_end) else $error("request after done");
    property p_mem_drv; memory_upper_drive_enable |-> $past(memory_init_done); endproperty
    a_mem_drv: assert property (p_mem_drv) else $error("drive before init");
    property p_proc_clr; $fell(proc_interrupt) |-> $past(ctl_wr, 2); endproperty
    a_proc_clr: assert property (p_proc_clr) else $error("processor irq dropped");
    property p_host_int; $fell(host_interrupt_out_n) |-> $past(ctl_wr, 2); endproperty
    a_host_int: assert property (p_host_int) else $error("host irq without write");
endmodule

// file: hpa_host_model.sv
// behavioural host microcontroller on the strobe bus
`timescale 1ns/100ps
module hpa_host_model (
    input wire logic pclk,
    input wire logic host_ready_n,
    input wire logic [31:0] host_data_out,
    output logic host_chip_select_n,
    output logic [1:0] host_data_strobes_n,
    output logic host_address_strobe_n,
    output logic host_read_not_write,
    output logic [1:0] access_type_select,
    output logic [3:0] host_byte_enables_n,
    output logic [15:0] host_address_pins,
    output logic [31:0] host_data_in
);
    initial
    begin
        host_chip_select_n = 1'b1;
        host_data_strobes_n = 2'b11;
        host_address_strobe_n = 1'b1;
        host_read_not_write = 1'b1;
        access_type_select = 2'b00;
        host_byte_enables_n = 4'h0;
        host_address_pins = 16'h0000;
        host_data_in = 32'h0000_0000;
    end
    task automatic acc(input logic [1:0] t, input logic rnw, input logic [15:0] pa,
            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        access_type_select <= t;
        host_read_not_write <= rnw;
        host_address_pins <= pa;
        // on reads only the half-select bit 16 keeps its value; the other data lines carry its inverse
        host_data_in <= rnw ? wd ^ 32'hfffe_ffff : wd;
        host_chip_select_n <= 1'b0;
        host_data_strobes_n <= 2'b10;
        repeat (8) @(posedge pclk);
        n = 0;
        while (host_ready_n !== 1'b0 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        rd = host_data_out;
        host_chip_select_n <= 1'b1;
        host_data_strobes_n <= 2'b11;
        repeat (8) @(posedge pclk);
        host_data_in <= ~host_data_in;
        host_address_pins <= ~pa;
        @(posedge pclk);
    endtask
endmodule

// file: tb_hpa_host_port.sv
// testbench: apb registers and host accesses of the host port
`timescale 1ns/100ps
module tb_hpa_host_port;
    import hpa_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [31:0] paddr, pwdata, prdata, r, last_addr;
    logic host_chip_select_n, host_address_strobe_n, host_read_not_write, host_ready_n;
    logic [1:0] host_data_strobes_n, access_type_select, dly;
    logic [3:0] host_byte_enables_n, bus_be;
    logic [15:0] host_address_pins;
    logic [31:0] host_data_in, host_data_out, host_data_oe_n, bus_addr, bus_wdata, bus_rdata;
    logic host_interrupt_out_n, proc_interrupt, memory_init_done, memory_upper_drive_enable;
    logic bus_req, bus_write, bus_done;
    logic [31:0] mem [16];
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    hpa_host_port hpa_host_port_inst (.*);
    hpa_host_model hpa_host_model_inst (.*);
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // internal memory answers each request after a short wait
    always @(posedge pclk)
    begin
        bus_done <= 1'b0;
        bus_rdata <= ~bus_rdata;
        if (bus_req && !bus_done)
        begin
            dly <= dly + 2'd1;
            if (dly == 2'd2)
            begin
                dly <= 2'd0;
                bus_done <= 1'b1;
                last_addr <= bus_addr;
                if (bus_write)
                    mem[bus_addr[5:2]] <= bus_wdata;
                bus_rdata <= mem[bus_addr[5:2]];
            end
        end
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic ha(input logic [1:0] t, input logic w, input logic [15:0] p, input logic [31:0] d);
        hpa_host_model_inst.acc(t, w, p, d, r);
    endtask
    task automatic hw(input logic [1:0] t, input logic w, input logic [31:0] d);
        logic [31:0] a;
        hpa_host_model_inst.acc(t, w, 16'h0000, {15'h0000, 1'b0, d[15:0]}, a);
        hpa_host_model_inst.acc(t, w, 16'h0000, {15'h0000, 1'b1, d[31:16]}, r);
        r = {r[15:0], a[15:0]};
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, memory_init_done, bus_done, dly} = '0;
        {paddr, pwdata, bus_rdata} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        memory_init_done <= 1'b1;
        @(posedge pclk);
        foreach (mem[i])
            mem[i] = 32'h0000_0000;
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, OFF_PORT_CFG + 4 * i, 32'h0000_0000);
            chk(r & 32'h0000_001f, 32'h0000_0000);
        end
        apb(1'b0, 32'h4300_0100, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        chk({31'h0000_0000, memory_upper_drive_enable}, 32'h0000_0001);
        $display("test registers done");
        apb(1'b1, OFF_PORT_CFG, 32'h0000_0019);
        apb(1'b1, OFF_HOST_CTL, 32'h0000_0004);
        chk({31'h0000_0000, host_interrupt_out_n}, 32'h0000_0000);
        ha(HPA_ACC_CTRL, 1'b0, 16'h0000, 32'h0000_0006);
        chk({host_interrupt_out_n, proc_interrupt}, 32'h0000_0003);
        apb(1'b1, OFF_HOST_CTL, 32'h0000_0002);
        chk({31'h0000_0000, proc_interrupt}, 32'h0000_0000);
        $display("test interrupts done");
        ha(HPA_ACC_ADDR, 1'b0, 16'h0000, 32'h0000_0020);
        ha(HPA_ACC_DATA_INC, 1'b0, 16'h0000, 32'ha5a5_0001);
        ha(HPA_ACC_DATA_INC, 1'b0, 16'h0000, 32'h5a5a_0002);
        chk(mem[8], 32'ha5a5_0001);
        chk(mem[9], 32'h5a5a_0002);
        ha(HPA_ACC_ADDR, 1'b0, 16'h0000, 32'h0000_0020);
        ha(HPA_ACC_DATA_INC, 1'b1, 16'h0000, 32'h0000_0000);
        chk(r, 32'ha5a5_0001);
        for (int i = 0; i < 2; i++)
        begin
            ha(HPA_ACC_DATA, 1'b1, 16'h0000, 32'h0000_0000);
            chk(r, 32'h5a5a_0002);
        end
        $display("test fullword done");
        apb(1'b1, OFF_PORT_CFG, 32'h0000_0011);
        hw(HPA_ACC_ADDR, 1'b0, 32'h0000_0030);
        hw(HPA_ACC_DATA_INC, 1'b0, 32'hcafe_f00d);
        chk(mem[12], 32'hcafe_f00d);
        hw(HPA_ACC_ADDR, 1'b0, 32'h0000_0030);
        hw(HPA_ACC_DATA, 1'b1, 32'h0000_0000);
        chk(r, 32'hcafe_f00d);
        $display("test halfword done");
        apb(1'b1, OFF_ADDR_TOP, 32'h0000_0012);
        apb(1'b1, OFF_ADDR_UMB, 32'h0000_0034);
        apb(1'b0, OFF_ADDR_UMB, 32'h0000_0000);
        chk(r & 32'h0000_00ff, 32'h0000_0034);
        apb(1'b1, OFF_PORT_CFG, 32'h0000_001b);
        ha(HPA_ACC_ADDR, 1'b0, 16'h0000, 32'hffff_0040);
        ha(HPA_ACC_DATA, 1'b0, 16'h0000, 32'h0bad_beef);
        chk(last_addr, 32'h1234_0040);
        $display("test page done");
        apb(1'b1, OFF_PORT_CFG, 32'h0000_0015);
        apb(1'b0, OFF_PORT_CFG, 32'h0000_0000);
        chk(r & 32'h0000_001f, 32'h0000_0015);
        chk({31'h0000_0000, memory_upper_drive_enable}, 32'h0000_0000);
        ha(HPA_ACC_DATA, 1'b0, 16'h0044, 32'h7777_0000);
        chk(last_addr, 32'h1234_0044);
        ha(HPA_ACC_DATA, 1'b1, 16'h0044, 32'h0000_0000);
        chk(r, 32'h7777_0000);
        $display("test nonmultiplexed done");
        give_verdict();
    end
endmodule
bind hpa_host_port hpa_monitor hpa_monitor_inst (.*);
